// file: inc/psp_pkg.sv
// shared constants for the phy static parameter bank
package psp_pkg;
  // octet indices; the wishbone byte address is four times the index
  localparam logic [6:0] PSP_IDX_DIST_CAP    = 7'h2c; // ranging capability octet
  localparam logic [6:0] PSP_IDX_CCA_WAIT    = 7'h2f; // clear-channel result interval
  localparam logic [6:0] PSP_IDX_PRE_MIN     = 7'h30; // preamble change minimum payload
  localparam logic [6:0] PSP_IDX_DIST_TX     = 7'h3c; // ranging transmit delay, low octet
  localparam logic [6:0] PSP_IDX_DIST_RX     = 7'h3e; // ranging receive delay, low octet
  localparam logic [6:0] PSP_IDX_TX_LAT      = 7'h40; // transmit start latency
  localparam logic [6:0] PSP_IDX_RX_LAT      = 7'h42; // receive start latency
  localparam logic [6:0] PSP_IDX_SYNC_LAT    = 7'h44; // sync to active latency
  localparam logic [6:0] PSP_IDX_TX_SETUP    = 7'h46; // transmit control setup
  localparam logic [6:0] PSP_IDX_RX_SETUP    = 7'h48; // receive control setup
  localparam logic [6:0] PSP_IDX_TX_HOLD     = 7'h4a; // transmit control hold
  localparam logic [6:0] PSP_IDX_RX_HOLD     = 7'h4c; // receive control hold
  localparam logic [6:0] PSP_IDX_PWR_FIRST   = 7'h50; // first output power step
  localparam logic [6:0] PSP_IDX_PWR_LAST    = 7'h5f; // last output power step
  localparam logic [6:0] PSP_IDX_STOP_REC    = 7'h60; // clock-stop recovery cycles
  localparam logic [6:0] PSP_IDX_NULL_CAP    = 7'h61; // tone-nulling capability
  localparam logic [6:0] PSP_IDX_HDR_LAT     = 7'h62; // header transfer latency
  localparam logic [6:0] PSP_IDX_TX_TAIL     = 7'h64; // transmit tail latency
  localparam logic [6:0] PSP_IDX_RX_TAIL_LOW = 7'h66; // receive tail latency, lowest rate
  localparam logic [6:0] PSP_IDX_RX_TAIL_OTH = 7'h68; // receive tail latency, other rates
  // fixed field values and layout
  localparam logic [7:0] PSP_PRE_MIN_OCTETS  = 8'h01; // fixed one-octet minimum payload
  localparam int         PSP_DIST_SUP_BIT    = 0;     // ranging supported
  localparam int         PSP_DIST_528_BIT    = 1;     // mandatory base precision
  localparam int         PSP_DIST_PREC_LSB   = 2;     // higher precisions, three bits
  localparam int         PSP_DIST_CNT_LSB    = 5;     // upper counter octets, two bits
  localparam int         PSP_DIST_RSV_BIT    = 7;     // reserved, reads zero
  localparam int         PSP_NULL_FLAG_BIT   = 0;     // null_carrier_flag position
  // reset values
  localparam logic [31:0] PSP_RST_DAT        = 32'h0000_0000;
  localparam logic [13:0] PSP_RST_CNT        = 14'h0000;
  localparam logic [2:0]  PSP_RST_SYNC       = 3'h7; // clock-stop request held in reset
  // timing
  localparam int PSP_CLK_PERIOD_NS = 10;   // 100 MHz
  localparam int PSP_CCA_UNIT_NS   = 500;  // one wait unit is 0.5 us
  localparam int PSP_CCA_UNIT_CYC  = PSP_CCA_UNIT_NS / PSP_CLK_PERIOD_NS; // longest time rounds down
  // clear-channel timer states
  typedef enum logic [1:0] {
    PSP_CCA_IDLE = 2'b00,
    PSP_CCA_WAIT = 2'b01,
    PSP_CCA_HOLD = 2'b10
  } psp_cca_state_e;
endpackage : psp_pkg

// file: hdl/psp_cca_timer.sv
// clear-channel measurement timer with a hard reporting deadline
`timescale 1ns/1ns
module psp_cca_timer import psp_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request from the controller's dynamic register logic
  input  wire logic       clear_channel_request_bit_i,
  input  wire logic [7:0] wait_units_i,
  // measurement engine
  input  wire logic       meas_done_i,
  input  wire logic       meas_busy_i,
  // result towards the controller
  output logic            cca_valid_o,
  output logic            cca_busy_o
);
  psp_cca_state_e state;   // timer state
  logic [13:0]    cnt;     // cycles left before the deadline
  logic           req_d;   // request delayed for edge detection
  logic           req_rise; // request set to one

  assign req_rise = clear_channel_request_bit_i && !req_d;

  // request edge detector
  always_ff @(posedge clk_i) begin
    if (rst_i) req_d <= 1'b0;
    else       req_d <= clear_channel_request_bit_i;
  end

  // deadline sequencer: report on measurement or when time runs out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= PSP_CCA_IDLE;
      cnt         <= PSP_RST_CNT;
      cca_valid_o <= 1'b0;
      cca_busy_o  <= 1'b0;
    end else begin
      cca_valid_o <= 1'b0;
      case (state)
        PSP_CCA_IDLE: begin
          if (req_rise) begin
            state <= PSP_CCA_WAIT;
            cnt   <= 14'(wait_units_i * PSP_CCA_UNIT_CYC); // [RQ1]
          end
        end
        PSP_CCA_WAIT: begin
          // late measurements give way to the deadline
          if (meas_done_i || cnt <= 14'h0001) begin // [RQ1]
            cca_valid_o <= 1'b1;
            cca_busy_o  <= meas_busy_i;
            state       <= PSP_CCA_HOLD;
          end else begin
            cnt <= cnt - 14'h0001;
          end
        end
        PSP_CCA_HOLD: begin
          // one result per request; wait for the bit to be cleared
          if (!clear_channel_request_bit_i) state <= PSP_CCA_IDLE;
        end
        default: state <= PSP_CCA_IDLE;
      endcase
    end
  end

  // helper: cycles since the request edge
  logic [13:0] age;
  always_ff @(posedge clk_i) begin
    if (rst_i)                      age <= PSP_RST_CNT;
    else if (req_rise)              age <= 14'h0001;
    else if (state == PSP_CCA_WAIT) age <= age + 14'h0001;
  end

  AST_CCA_DEADLINE: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    (state == PSP_CCA_WAIT) |-> (age <= 14'(wait_units_i * PSP_CCA_UNIT_CYC) + 14'h0001))
    else $error("clear-channel result later than the wait interval");
endmodule : psp_cca_timer

// file: hdl/psp_stop_recovery.sv
// clock-stop recovery counter that flags the interface clock as stable
`timescale 1ns/1ns
module psp_stop_recovery import psp_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // clock-stop request pin and recovery count
  input  wire logic       clock_stop_request_i,
  input  wire logic [7:0] recovery_cycles_i,
  // stable indication
  output logic            clock_stable_o
);
  logic [2:0] sync;  // three-stage synchroniser
  logic       filt;  // request level once stages two and three agree
  logic [7:0] left;  // cycles still to wait

  // synchroniser chain
  always_ff @(posedge clk_i) begin
    if (rst_i) sync <= PSP_RST_SYNC;
    else       sync <= {sync[1:0], clock_stop_request_i};
  end

  // accept a change only when the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i)                filt <= 1'b1;
    else if (sync[1] == sync[2]) filt <= sync[2];
  end

  // count down after release, stable only at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left           <= 8'h00;
      clock_stable_o <= 1'b0;
    end else if (filt) begin
      left           <= recovery_cycles_i; // [RQ5]
      clock_stable_o <= 1'b0;
    end else if (left != 8'h00) begin
      left           <= left - 8'h01;
      clock_stable_o <= 1'b0;
    end else begin
      clock_stable_o <= 1'b1; // [RQ5]
    end
  end

  sequence s_release;
    $fell(filt);
  endsequence

  AST_STOP_HOLDOFF: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    s_release ##0 (recovery_cycles_i != 8'h00) |-> !clock_stable_o [*2])
    else $error("clock reported stable too early after clock-stop release");
endmodule : psp_stop_recovery

// file: hdl/psp_rom_top.sv
// phy static parameter bank behind a classic wishbone slave
// Operation
// [RQ1] report clear-channel result within wait interval
// [RQ2] preamble change needs one-octet payload minimum
// [RQ3] ranging capability bit layout, bit seven zero
// [RQ4] ranging delays two octets, 4224 MHz ticks
// [RQ5] clock unusable until recovery cycles elapse
// [RQ6] tone-nulling support bit zero, rest zero
// [RQ7] parameters read-only, writes change nothing
// [RQ8] low octet even address, reserved reads zero
`timescale 1ns/1ns
module psp_rom_top import psp_pkg::*; #(
  // parameter values of this transceiver
  parameter logic [15:0]  TX_LAT_VAL      = 16'h0000,
  parameter logic [15:0]  RX_LAT_VAL      = 16'h0000,
  parameter logic [15:0]  SYNC_LAT_VAL    = 16'h0000,
  parameter logic [15:0]  TX_SETUP_VAL    = 16'h0000,
  parameter logic [15:0]  RX_SETUP_VAL    = 16'h0000,
  parameter logic [15:0]  TX_HOLD_VAL     = 16'h0000,
  parameter logic [15:0]  RX_HOLD_VAL     = 16'h0000,
  parameter logic [127:0] PWR_STEPS_VAL   = 128'h0,
  parameter logic [7:0]   STOP_REC_VAL    = 8'h00,
  parameter logic         NULL_SUP_VAL    = 1'b0,
  parameter logic [15:0]  HDR_LAT_VAL     = 16'h0000,
  parameter logic [15:0]  TX_TAIL_VAL     = 16'h0000,
  parameter logic [15:0]  RX_TAIL_LOW_VAL = 16'h0000,
  parameter logic [15:0]  RX_TAIL_OTH_VAL = 16'h0000,
  parameter logic [7:0]   CCA_WAIT_VAL    = 8'h00,
  parameter logic         DIST_SUP_VAL    = 1'b0,
  parameter logic [2:0]   DIST_PREC_VAL   = 3'h0,
  parameter logic [1:0]   DIST_CNT_VAL    = 2'h0,
  parameter logic [15:0]  DIST_TX_VAL     = 16'h0000,
  parameter logic [15:0]  DIST_RX_VAL     = 16'h0000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // clear-channel request and measurement
  input  wire logic        clear_channel_request_bit_i,
  input  wire logic        meas_done_i,
  input  wire logic        meas_busy_i,
  output logic             cca_valid_o,
  output logic             cca_busy_o,
  // clock-stop handling
  input  wire logic        clock_stop_request_i,
  output logic             clock_stable_o
);
  logic [6:0]  idx;          // octet index from the byte address
  logic        in_map;       // address inside the parameter window
  logic        req;          // new bus request this cycle
  logic [7:0]  next_octet;   // decoded octet
  logic [15:0] pair;         // selected two-octet parameter
  logic        pair_hit;     // index falls on a two-octet parameter
  logic [7:0]  dist_cap;     // ranging capability octet
  logic [7:0]  null_cap;     // tone-nulling capability octet
  logic [7:0]  pwr_tab [16]; // output power steps

  assign idx    = adr_i[8:2];
  assign in_map = (adr_i[31:9] == 23'h0);
  assign req    = cyc_i && stb_i && !ack_o;

  // power step table, one entry per level
  for (genvar g = 0; g < 16; g++) begin : g_pwr
    assign pwr_tab[g] = PWR_STEPS_VAL[g*8 +: 8];
  end

  // capability octets assembled from their fields
  always_comb begin
    dist_cap                    = 8'h00;
    dist_cap[PSP_DIST_SUP_BIT]  = DIST_SUP_VAL;                             // [RQ3]
    dist_cap[PSP_DIST_528_BIT]  = DIST_SUP_VAL;                             // [RQ3]
    dist_cap[PSP_DIST_PREC_LSB +: 3] = DIST_SUP_VAL ? DIST_PREC_VAL : 3'h0; // [RQ3]
    dist_cap[PSP_DIST_CNT_LSB +: 2]  = DIST_SUP_VAL ? DIST_CNT_VAL : 2'h0;  // [RQ3]
    dist_cap[PSP_DIST_RSV_BIT]  = 1'b0;                                     // [RQ3]
    null_cap                    = 8'h00;                                    // [RQ6]
    null_cap[PSP_NULL_FLAG_BIT] = NULL_SUP_VAL;                             // [RQ6]
  end

  // two-octet parameter select on the even index
  always_comb begin
    pair     = 16'h0000;
    pair_hit = 1'b1;
    if (idx[6:1] == PSP_IDX_DIST_TX[6:1]) begin
      pair = DIST_TX_VAL; // [RQ4]
    end else if (idx[6:1] == PSP_IDX_DIST_RX[6:1]) begin
      pair = DIST_RX_VAL; // [RQ4]
    end else if (idx[6:1] == PSP_IDX_TX_LAT[6:1]) begin
      pair = TX_LAT_VAL;
    end else if (idx[6:1] == PSP_IDX_RX_LAT[6:1]) begin
      pair = RX_LAT_VAL;
    end else if (idx[6:1] == PSP_IDX_SYNC_LAT[6:1]) begin
      pair = SYNC_LAT_VAL;
    end else if (idx[6:1] == PSP_IDX_TX_SETUP[6:1]) begin
      pair = TX_SETUP_VAL;
    end else if (idx[6:1] == PSP_IDX_RX_SETUP[6:1]) begin
      pair = RX_SETUP_VAL;
    end else if (idx[6:1] == PSP_IDX_TX_HOLD[6:1]) begin
      pair = TX_HOLD_VAL;
    end else if (idx[6:1] == PSP_IDX_RX_HOLD[6:1]) begin
      pair = RX_HOLD_VAL;
    end else if (idx[6:1] == PSP_IDX_HDR_LAT[6:1]) begin
      pair = HDR_LAT_VAL;
    end else if (idx[6:1] == PSP_IDX_TX_TAIL[6:1]) begin
      pair = TX_TAIL_VAL;
    end else if (idx[6:1] == PSP_IDX_RX_TAIL_LOW[6:1]) begin
      pair = RX_TAIL_LOW_VAL;
    end else if (idx[6:1] == PSP_IDX_RX_TAIL_OTH[6:1]) begin
      pair = RX_TAIL_OTH_VAL;
    end else begin
      pair_hit = 1'b0;
    end
  end

  // octet decode; anything not listed reads zero
  always_comb begin
    next_octet = 8'h00; // [RQ8]
    if (!in_map) begin
      next_octet = 8'h00;
    end else if (pair_hit) begin
      next_octet = idx[0] ? pair[15:8] : pair[7:0]; // [RQ8]
    end else if (idx >= PSP_IDX_PWR_FIRST && idx <= PSP_IDX_PWR_LAST) begin
      next_octet = pwr_tab[idx[3:0]];
    end else if (idx == PSP_IDX_STOP_REC) begin
      next_octet = STOP_REC_VAL; // [RQ5]
    end else if (idx == PSP_IDX_NULL_CAP) begin
      next_octet = null_cap; // [RQ6]
    end else if (idx == PSP_IDX_CCA_WAIT) begin
      next_octet = CCA_WAIT_VAL; // [RQ1]
    end else if (idx == PSP_IDX_PRE_MIN) begin
      next_octet = PSP_PRE_MIN_OCTETS; // [RQ2]
    end else if (idx == PSP_IDX_DIST_CAP) begin
      next_octet = dist_cap; // [RQ3]
    end
  end

  // single-cycle slave: ack the cycle after the strobe, writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= PSP_RST_DAT;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= {24'h000000, next_octet};
      end else if (req) begin
        dat_o <= PSP_RST_DAT; // [RQ7]
      end
    end
  end

  // clear-channel result timing
  psp_cca_timer u_cca (
    .clk_i                       (clk_i),
    .rst_i                       (rst_i),
    .clear_channel_request_bit_i (clear_channel_request_bit_i),
    .wait_units_i                (CCA_WAIT_VAL),
    .meas_done_i                 (meas_done_i),
    .meas_busy_i                 (meas_busy_i),
    .cca_valid_o                 (cca_valid_o),
    .cca_busy_o                  (cca_busy_o)
  );

  // interface clock recovery after clock stop
  psp_stop_recovery u_stop (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .clock_stop_request_i (clock_stop_request_i),
    .recovery_cycles_i    (STOP_REC_VAL),
    .clock_stable_o       (clock_stable_o)
  );

  // bus request sequences used below
  sequence s_rd(logic [6:0] at);
    req && !we_i && in_map && idx == at;
  endsequence

  sequence s_wr;
    req && we_i;
  endsequence

  AST_DIST_LAYOUT: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
    s_rd(PSP_IDX_DIST_CAP) |=> ack_o && dat_o[7] == 1'b0 && dat_o[1] == dat_o[0] && dat_o[31:8] == 24'h0)
    else $error("ranging capability octet has a bad layout");

  AST_DIST_DELAY: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    s_rd(PSP_IDX_DIST_TX + 7'h01) |=> ack_o && dat_o == {24'h0, DIST_TX_VAL[15:8]})
    else $error("ranging transmit delay high octet wrong");

  AST_NULL_LAYOUT: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    s_rd(PSP_IDX_NULL_CAP) |=> ack_o && dat_o == {31'h0, NULL_SUP_VAL})
    else $error("tone-nulling octet has a bad layout");

  AST_WRITE_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    s_wr |=> ack_o && dat_o == PSP_RST_DAT ##1 !ack_o)
    else $error("write not acknowledged as a no-op");

  AST_PAIR_ORDER: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(PSP_IDX_TX_LAT) |=> ack_o && dat_o[7:0] == TX_LAT_VAL[7:0])
    else $error("low octet not at the even address");

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(7'h4e) or s_rd(7'h6a) |=> ack_o && dat_o == 32'h0)
    else $error("reserved address does not read zero");

  AST_MIN_PAYLOAD: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    s_rd(PSP_IDX_PRE_MIN) |=> dat_o == {24'h0, PSP_PRE_MIN_OCTETS})
    else $error("preamble change minimum payload not one octet");

  // every taken request is answered on the next edge
  AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    req |=> ack_o)
    else $error("request not acknowledged on the next edge");

  // acknowledge is a single-cycle pulse
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");

  // read data only moves on a taken request
  AST_DATA_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    !req |=> $stable(dat_o))
    else $error("read data changed without a request");

  // addresses above the parameter window read zero
  AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    req && !we_i && !in_map |=> dat_o == 32'h0)
    else $error("unmapped address does not read zero");

  // high octet of a pair sits at the odd address
  AST_PAIR_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(PSP_IDX_TX_LAT + 7'h01) |=> dat_o == {24'h0, TX_LAT_VAL[15:8]})
    else $error("high octet not at the odd address");

  // ranging transmit delay low octet
  AST_DIST_TX_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    s_rd(PSP_IDX_DIST_TX) |=> dat_o == {24'h0, DIST_TX_VAL[7:0]})
    else $error("ranging transmit delay low octet wrong");

  // ranging receive delay low octet
  AST_DIST_RX_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    s_rd(PSP_IDX_DIST_RX) |=> dat_o == {24'h0, DIST_RX_VAL[7:0]})
    else $error("ranging receive delay low octet wrong");

  // ranging receive delay high octet
  AST_DIST_RX_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    s_rd(PSP_IDX_DIST_RX + 7'h01) |=> dat_o == {24'h0, DIST_RX_VAL[15:8]})
    else $error("ranging receive delay high octet wrong");

  // first output power step
  AST_PWR_FIRST: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(PSP_IDX_PWR_FIRST) |=> dat_o == {24'h0, PWR_STEPS_VAL[7:0]})
    else $error("first power step wrong");

  // last output power step
  AST_PWR_LAST: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(PSP_IDX_PWR_LAST) |=> dat_o == {24'h0, PWR_STEPS_VAL[127:120]})
    else $error("last power step wrong");

  // clock-stop recovery count octet
  AST_STOP_OCTET: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    s_rd(PSP_IDX_STOP_REC) |=> dat_o == {24'h0, STOP_REC_VAL})
    else $error("clock-stop recovery octet wrong");

  // clear-channel wait octet
  AST_CCA_OCTET: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    s_rd(PSP_IDX_CCA_WAIT) |=> dat_o == {24'h0, CCA_WAIT_VAL})
    else $error("clear-channel wait octet wrong");

  // receive tail latency, other rates, low octet
  AST_TAIL_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(PSP_IDX_RX_TAIL_OTH) |=> dat_o == {24'h0, RX_TAIL_OTH_VAL[7:0]})
    else $error("receive tail latency low octet wrong");

  // header transfer latency low octet
  AST_HDR_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(PSP_IDX_HDR_LAT) |=> dat_o == {24'h0, HDR_LAT_VAL[7:0]})
    else $error("header transfer latency low octet wrong");

  // further reserved places read zero
  AST_RESERVED_TOP: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    s_rd(7'h4f) or s_rd(7'h7f) |=> dat_o == 32'h0)
    else $error("upper reserved address does not read zero");
endmodule : psp_rom_top

// file: bench/psp_meas_model.sv
// measurement engine model that answers clear-channel requests
`timescale 1ns/1ns
module psp_meas_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request and shape of the answer
  input  wire logic       request_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       busy_val_i,
  // measurement result
  output logic            meas_done_o,
  output logic            meas_busy_o
);
  logic       req_q; // request level one cycle ago
  logic [7:0] cnt;   // cycles left before answering, zero when idle
  // start counting on a rising request; a zero delay never answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      cnt   <= 8'h00;
    end else begin
      req_q <= request_i;
      if (request_i && !req_q) begin
        cnt <= delay_i;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // result pulse; outside it busy shows the opposite level, never a kind guess
  assign meas_done_o = (cnt == 8'h01);
  assign meas_busy_o = meas_done_o ? busy_val_i : ~busy_val_i;
endmodule : psp_meas_model

// file: bench/tb.sv
// self-checking bench for the static parameter bank
`timescale 1ns/1ns
module tb import psp_pkg::*;;
  localparam int CCA_W  = 2; // wait units, deadline CCA_W*50 cycles
  localparam int STOP_N = 6; // clock-stop recovery cycles
  localparam logic [15:0]  TX_LAT_P  = 16'h12a4; // transmit start latency
  localparam logic [15:0]  TAIL_P    = 16'hbe07; // receive tail latency, other rates
  localparam logic [127:0] PWR_P     = 128'hc500_0000_0000_0000_0000_0000_0000_003c; // power steps
  localparam logic [15:0]  DIST_TX_P = 16'h5a3c; // ranging transmit delay
  localparam logic [15:0]  DIST_RX_P = 16'h0f81; // ranging receive delay
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
  logic        req = 1'b0, stop_req = 1'b0, m_busy = 1'b0;
  logic [7:0]  m_delay = 8'h00;
  logic        meas_done, meas_busy, cca_valid, cca_busy, stable;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [7:0]  bus_q[$]; // expected read octets in order
  logic        cca_q[$]; // expected channel results in order
  // octet index and expected value, reserved places last
  logic [6:0]  t_idx [18] = '{7'h40, 7'h41, 7'h68, 7'h69, 7'h50, 7'h5f, 7'h60, 7'h61, 7'h2c,
                              7'h2f, 7'h30, 7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h4e, 7'h6a, 7'h7f};
  logic [7:0]  t_exp [18] = '{8'ha4, 8'h12, 8'h07, 8'hbe, 8'h3c, 8'hc5, 8'h06, 8'h01, 8'h57,
                              8'h02, PSP_PRE_MIN_OCTETS, 8'h3c, 8'h5a, 8'h81, 8'h0f, 8'h00, 8'h00, 8'h00};
  // device under test with distinct parameter values
  psp_rom_top #(.TX_LAT_VAL(TX_LAT_P), .RX_TAIL_OTH_VAL(TAIL_P),
    .PWR_STEPS_VAL(PWR_P), .STOP_REC_VAL(8'(STOP_N)),
    .NULL_SUP_VAL(1'b1), .CCA_WAIT_VAL(8'(CCA_W)), .DIST_SUP_VAL(1'b1), .DIST_PREC_VAL(3'h5),
    .DIST_CNT_VAL(2'h2), .DIST_TX_VAL(DIST_TX_P), .DIST_RX_VAL(DIST_RX_P)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .clear_channel_request_bit_i(req), .meas_done_i(meas_done), .meas_busy_i(meas_busy),
    .cca_valid_o(cca_valid), .cca_busy_o(cca_busy), .clock_stop_request_i(stop_req),
    .clock_stable_o(stable));
  // measurement engine on the far side
  psp_meas_model i_meas (.clk_i(clk_i), .rst_i(rst_i), .request_i(req), .delay_i(m_delay),
    .busy_val_i(m_busy), .meas_done_o(meas_done), .meas_busy_o(meas_busy));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // compare one value and count it
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // print counts and verdict, then stop
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // one classic wishbone cycle; the expected octet goes to the queue
  task bus(input logic [31:0] adr, input logic we, input logic [7:0] exp);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= adr;
    we_i  <= we;
    dat_i <= $urandom;
    sel_i <= 4'($urandom);
    bus_q.push_back(exp);
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h0, 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus
  // one clear-channel measurement; zero delay means the engine stays silent
  task cca_run(input logic [7:0] dly, input logic busy);
    int n;
    @(posedge clk_i);
    req     <= 1'b1;
    m_delay <= dly;
    m_busy  <= busy;
    cca_q.push_back(dly == 8'h00 ? ~busy : busy);
    n = 0;
    do begin @(posedge clk_i); n++; end while (cca_valid !== 1'b1 && n < 300);
    if (dly == 8'h00) chk("deadline", 32'(n >= CCA_W*50-2 && n <= CCA_W*50+3), 32'h1);
    else chk("answer time", 32'(n <= int'(dly)+4), 32'h1);
    repeat (CCA_W*50+10) @(posedge clk_i); // a held request must give no second result
    req <= 1'b0;
    @(posedge clk_i);
    $display("clear-channel test done, delay %0d", dly);
  endtask : cca_run
  // wait for the stable flag to reach a level, counting cycles
  task wait_stable(input logic lvl, output int n);
    n = 0;
    do begin @(posedge clk_i); n++; end while (stable !== lvl && n < 100);
  endtask : wait_stable
  // results are matched against the oldest note as they appear
  always @(posedge clk_i) begin
    if (ack_o === 1'b1) begin
      if (bus_q.size() == 0) chk("spare ack", 32'h1, 32'h0);
      else chk("read data", dat_o, {24'h0, bus_q.pop_front()});
    end
    if (cca_valid === 1'b1) begin
      if (cca_q.size() == 0) chk("spare result", 32'h1, 32'h0);
      else chk("channel result", {31'h0, cca_busy}, {31'h0, cca_q.pop_front()});
    end
  end
  // main sequence
  initial begin
    int n;
    int k;
    void'($urandom(32'h2f59));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_stable(1'b1, n); // the clock counts as unusable until stable
    chk("recovery after reset", 32'(n >= STOP_N+1 && n <= STOP_N+7), 32'h1);
    for (int i = 0; i < 18; i++) bus({23'h0, t_idx[i], 2'b00}, 1'b0, t_exp[i]);
    $display("parameter read test done");
    repeat (8) begin
      k = $urandom_range(17);
      bus({23'h0, t_idx[k], 2'b00}, 1'b1, 8'h00);
      bus({23'h0, t_idx[k], 2'b00}, 1'b0, t_exp[k]);
    end
    $display("write protection test done");
    repeat (4) begin
      bus({23'($urandom_range(32'h7fffff, 1)), 7'($urandom), 2'b00}, 1'b0, 8'h00);
      bus({23'h0, 7'($urandom_range(32'h7f, 32'h6a)), 2'b00}, 1'b0, 8'h00);
    end
    $display("unmapped and reserved test done");
    cca_run(8'h01, 1'b1);
    cca_run(8'h28, 1'b0);
    cca_run(8'h00, 1'b1);
    cca_run(8'($urandom_range(60, 2)), 1'($urandom));
    @(posedge clk_i);
    stop_req <= 1'b1;
    wait_stable(1'b0, n);
    chk("stop takes clock away", 32'(n <= 6), 32'h1);
    repeat (5) @(posedge clk_i);
    stop_req <= 1'b0;
    wait_stable(1'b1, n);
    chk("recovery time", 32'(n >= STOP_N+1 && n <= STOP_N+6), 32'h1);
    $display("clock-stop test done");
    wrap_up();
  end
  // watchdog against a hang
  initial begin
    #(10*30000);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : tb
